// ===== src/per_phase_readback.v
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "per_consts.vh"
module per_phase_readback #(
   parameter TICK_CYCLES = `PER_TICK_CYCLES
) (
   input  wire        clk_in,           // system clock, 125 MHz
   input  wire        rst_in,           // sync reset, active high
   input  wire        psel_in,          // apb select
   input  wire        penable_in,       // apb enable
   input  wire        pwrite_in,        // apb direction
   input  wire [11:0] paddr_in,         // apb byte address
   input  wire [31:0] pwdata_in,        // apb write data
   output wire        pready_out,       // apb ready
   output reg  [31:0] prdata_out,       // apb read data
   output wire        pslverr_out,      // apb error
   input  wire [15:0] main_phase_in,    // main loop detector, signed
   input  wire [15:0] aux_phase_in,     // aux loop detector, signed
   output wire        loop_source_select_out, // 1 = aux loop
   output wire [7:0]  alarm_delay_out   // phase alarm delay setting
);
   // one-hot register selects
   localparam SEL_NONE  = 4'b0000;
   localparam SEL_LO    = 4'b0001;
   localparam SEL_HI    = 4'b0010;
   localparam SEL_CTRL  = 4'b0100;
   localparam SEL_ALARM = 4'b1000;

   // registers and their next values
   reg  [7:0]  loop_ctrl_reg;
   reg  [7:0]  loop_ctrl_next;
   reg  [7:0]  alarm_delay_reg;
   reg  [7:0]  alarm_delay_next;
   reg  [15:0] sample_reg;
   reg  [15:0] sample_next;
   reg  [15:0] snap_reg;
   reg  [15:0] snap_next;
   reg  [31:0] tick_cnt_reg;
   reg  [31:0] tick_cnt_next;
   reg         tick_reg;
   reg         tick_next;
   reg  [31:0] rdata_next;
   wire [15:0] avg;
   wire [3:0]  addr_sel;
   wire        setup_ph;
   wire        access_ph;
   wire        wr_en;
   wire        rd_setup;
   wire        mapped;
   wire        tick_wrap;

   // address decode shared by read, write, snapshot and error paths
   function [3:0] decode_addr;
      input [11:0] addr;
      begin
         if (addr == `PER_ADDR_PHASE_LO)
            decode_addr = SEL_LO;
         else if (addr == `PER_ADDR_PHASE_HI)
            decode_addr = SEL_HI;
         else if (addr == `PER_ADDR_LOOP_CTRL)
            decode_addr = SEL_CTRL;
         else if (addr == `PER_ADDR_ALARM_DELAY)
            decode_addr = SEL_ALARM;
         else
            decode_addr = SEL_NONE;
      end
   endfunction

   // bus phases
   assign setup_ph    = psel_in & ~penable_in;
   assign access_ph   = psel_in & penable_in;
   assign wr_en       = access_ph & pwrite_in;
   assign rd_setup    = setup_ph & ~pwrite_in;
   assign addr_sel    = decode_addr(paddr_in);
   assign mapped      = |addr_sel;

   // zero wait states; unmapped accesses flag an error
   assign pready_out  = 1'b1;
   assign pslverr_out = access_ph & ~mapped;

   assign loop_source_select_out = loop_ctrl_reg[`PER_LOOP_SEL_BIT];
   assign alarm_delay_out        = alarm_delay_reg;

   // filter update rate divider
   assign tick_wrap = (tick_cnt_reg >= TICK_CYCLES - 1);

   always @*
   begin
      if (tick_wrap)
      begin
         tick_cnt_next = 32'h00000000;
         tick_next     = 1'b1;
      end
      else
      begin
         tick_cnt_next = tick_cnt_reg + 32'h00000001;
         tick_next     = 1'b0;
      end
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg     <= 1'b0;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_next;
         tick_reg     <= tick_next;
      end
   end

   // detector source selection, registered once before the filter
   always @*
   begin
      if (loop_ctrl_reg[`PER_LOOP_SEL_BIT])
         sample_next = aux_phase_in;
      else
         sample_next = main_phase_in;
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
         sample_reg <= 16'h0000;
      else
         sample_reg <= sample_next;
   end

   // smoothing filter, signed in and out
   per_avg_filter #(
      .WIDTH (16),
      .SHIFT (`PER_FILTER_SHIFT)
   ) u_filter (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .tick_in   (tick_reg),
      .sample_in (sample_reg),
      .avg_out   (avg)
   );

   // low-byte read freezes the whole word so the high byte matches
   always @*
   begin
      snap_next = snap_reg;
      if (rd_setup && addr_sel == SEL_LO)
         snap_next = avg;
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
         snap_reg <= 16'h0000;
      else
         snap_reg <= snap_next;
   end

   // control register: all eight bits stored, bit 4 picks the source
   always @*
   begin
      loop_ctrl_next = loop_ctrl_reg;
      if (wr_en && addr_sel == SEL_CTRL)
         loop_ctrl_next = pwdata_in[7:0];
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
         loop_ctrl_reg <= `PER_LOOP_CTRL_RESET;
      else
         loop_ctrl_reg <= loop_ctrl_next;
   end

   // alarm delay keeps six bits; top two read as zero
   always @*
   begin
      alarm_delay_next = alarm_delay_reg;
      if (wr_en && addr_sel == SEL_ALARM)
         alarm_delay_next = {2'b00, pwdata_in[5:0]};
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
         alarm_delay_reg <= `PER_ALARM_RESET;
      else
         alarm_delay_reg <= alarm_delay_next;
   end

   // read data select; unused bits read zero
   always @*
   begin
      rdata_next = 32'h00000000;
      if (addr_sel == SEL_LO)
         rdata_next = {24'h000000, avg[7:0]};
      else if (addr_sel == SEL_HI)
         rdata_next = {24'h000000, snap_reg[15:8]};
      else if (addr_sel == SEL_CTRL)
         rdata_next = {24'h000000, loop_ctrl_reg};
      else if (addr_sel == SEL_ALARM)
         rdata_next = {24'h000000, alarm_delay_reg};
   end

   // read data launched at setup, stands through the access phase
   always @(posedge clk_in)
   begin
      if (rst_in)
         prdata_out <= 32'h00000000;
      else if (setup_ph)
         prdata_out <= rdata_next;
   end
endmodule // per_phase_readback

// ===== src/per_consts.vh
`ifndef PER_CONSTS_VH
`define PER_CONSTS_VH
// register indices as printed; byte address is four times the index
`define PER_IDX_PHASE_LO     8'h77
`define PER_IDX_PHASE_HI     8'h78
`define PER_IDX_LOOP_CTRL    8'h4B
`define PER_IDX_ALARM_DELAY  8'h79
`define PER_ADDR_PHASE_LO    12'h1DC
`define PER_ADDR_PHASE_HI    12'h1E0
`define PER_ADDR_LOOP_CTRL   12'h12C
`define PER_ADDR_ALARM_DELAY 12'h1E4
`define PER_LOOP_SEL_BIT     4
`define PER_LOOP_CTRL_RESET  8'h00
`define PER_ALARM_RESET      8'h00
`define PER_CLK_HZ           125000000
`define PER_FILTER_BW_HZ     100
// smoothing update rate: about 2*pi*bw times 2^shift per second
`define PER_FILTER_SHIFT     4
`define PER_TICK_CYCLES      ((`PER_CLK_HZ) / (628 * (`PER_FILTER_BW_HZ) * 16 / 100))
`endif

// ===== src/per_avg_filter.v
`timescale 1ns/1ps
// first-order smoothing of a signed sample, updated once per tick
module per_avg_filter #(
   parameter WIDTH = 16,
   parameter SHIFT = 4
) (
   input  wire             clk_in,     // system clock
   input  wire             rst_in,     // sync reset, active high
   input  wire             tick_in,    // update enable pulse
   input  wire [WIDTH-1:0] sample_in,  // signed detector sample
   output wire [WIDTH-1:0] avg_out     // signed smoothed value
);
   reg  signed [WIDTH+SHIFT-1:0] acc_reg;
   wire signed [WIDTH+SHIFT-1:0] samp_ext;
   wire signed [WIDTH+SHIFT:0]   diff;
   wire signed [WIDTH+SHIFT:0]   step;

   assign samp_ext = {{SHIFT{sample_in[WIDTH-1]}}, sample_in} <<< SHIFT;
   // guard bit so a full-scale swing between sources cannot wrap
   assign diff     = {samp_ext[WIDTH+SHIFT-1], samp_ext} - {acc_reg[WIDTH+SHIFT-1], acc_reg};
   assign step     = diff >>> SHIFT;

   always @(posedge clk_in)
   begin
      if (rst_in)
         acc_reg <= {(WIDTH+SHIFT){1'b0}};
      else if (tick_in)
         acc_reg <= acc_reg + step[WIDTH+SHIFT-1:0];
   end

   assign avg_out = acc_reg[WIDTH+SHIFT-1:SHIFT];
endmodule // per_avg_filter

// ===== dv/per_pr_asserts.sv
`timescale 1ns/1ps
module per_pr_asserts (
   input wire        clk_in,      // clk
   input wire        rst_in,      // rst
   input wire        psel_in,     // sel
   input wire        penable_in,  // en
   input wire        pwrite_in,   // dir
   input wire [11:0] paddr_in,    // addr
   input wire [31:0] pwdata_in,   // wdata
   input wire        pready_out,  // rdy
   input wire [31:0] prdata_out,  // rdata
   input wire        pslverr_out, // err
   input wire        loop_source_select_out // src
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wire acc = psel_in && penable_in;
   wire wr  = acc && pwrite_in && paddr_in == 12'h12C;
   wire map = paddr_in == 12'h1DC || paddr_in == 12'h1E0 || paddr_in == 12'h12C
              || paddr_in == 12'h1E4;
   ready_now_a: assert property (acc |-> pready_out) else $error("no ready");
   upper_zero_a: assert property (acc && !pwrite_in |-> prdata_out[31:8] == 24'h0)
      else $error("upper bits");
   sel_write_a: assert property (wr |=> loop_source_select_out == $past(pwdata_in[4]))
      else $error("select");
   sel_hold_a: assert property (!wr |=> $stable(loop_source_select_out))
      else $error("select moved");
   unmap_err_a: assert property (acc |-> pslverr_out == !map) else $error("slverr");
   ro_quiet_a: assert property (acc && pwrite_in && paddr_in == 12'h1E0 |-> !pslverr_out)
      else $error("ro error");
   cover property (wr);
   cover property (acc && !map);
   cover property (acc && !pwrite_in && paddr_in == 12'h1E0 && prdata_out[7]);
endmodule // per_pr_asserts

// ===== dv/per_phase_readback_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module per_phase_readback_tb;
   logic        clk_in, rst_in, psel_in, penable_in, pwrite_in, rdy, err, sel, er;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata, rd;
   logic [15:0] main_in, aux_in, v;
   logic [7:0]  lo, dly, ad;
   int          fails = 0, tests_run = 0, cyc = 0;
   per_phase_readback #(.TICK_CYCLES(4)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(rdy), .prdata_out(prdata),
      .pslverr_out(err), .main_phase_in(main_in), .aux_phase_in(aux_in),
      .loop_source_select_out(sel), .alarm_delay_out(ad));
   initial begin clk_in = 0; forever #4 clk_in = ~clk_in; end
   always @(posedge clk_in) begin cyc <= cyc + 1; if (cyc == 20000)
      begin fails++; end_of_test(); end end
   function bit near(input [15:0] a, input [15:0] b);
      near = ($signed(a) - $signed(b) < 20) && ($signed(b) - $signed(a) < 20);
   endfunction
   // alarm delay keeps only its six low bits
   function logic [7:0] exp_alarm(input [7:0] d);
      exp_alarm = {2'b00, d[5:0]};
   endfunction
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge clk_in);
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1;
      @(posedge clk_in);
      while (rdy !== 1'b1) @(posedge clk_in);
      rd = prdata;
      er = err;
      psel_in <= 0;
      penable_in <= 0;
   endtask
   task end_of_test;
      $display("checks %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {rst_in, psel_in, penable_in, pwrite_in} = 4'h8; paddr_in = 0; pwdata_in = 0;
      main_in = 0; aux_in = 0; void'($urandom(32'hBD32A8B3));
      repeat (8) @(posedge clk_in); rst_in <= 0;
      apb(0, 12'h1E0, 0); `CHK(rd, 32'h0)
      apb(0, 12'h1F0, 0); `CHK(er, 1'b1)
      dly = 8'($urandom);
      apb(1, 12'h1E4, {24'h000000, dly});
      apb(0, 12'h1E4, 0);
      `CHK(rd, {24'h000000, exp_alarm(dly)})
      `CHK(ad, exp_alarm(dly))
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_in); main_in <= {1'b1, 15'($urandom)}; aux_in <= 16'($urandom) >> 1;
         apb(1, 12'h12C, 32'(i) << 4);
         repeat (3000) @(posedge clk_in);
         `CHK(sel, i[0])
         apb(0, 12'h12C, 0);
         `CHK(rd[4], i[0])
         v = i ? aux_in : main_in;
         for (int k = 0; k < 2; k++) begin
            apb(0, 12'h1DC, 0); lo = rd[7:0]; apb(0, 12'h1E0, 0);
            `CHK(near({rd[7:0], lo}, v), 1'b1)
            apb(1, 12'h1DC, 32'h5A);
            `CHK(er, 1'b0)
            apb(1, 12'h1E0, 32'hA5);
            `CHK(er, 1'b0)
         end
         $display("test %0d done", i);
      end
      end_of_test();
   end
endmodule // per_phase_readback_tb
bind per_phase_readback per_pr_asserts chk_u (.clk_in(clk_in), .rst_in(rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out),
   .pslverr_out(pslverr_out), .loop_source_select_out(loop_source_select_out));
